// >>> rtl/diag_led_pkg.sv
package diag_led_pkg;

  // ****************************************
  // timebase
  // ****************************************
  localparam int unsigned CLK_HZ_DEF     = 40_000_000;
  localparam int unsigned MARKER_MS      = 3000;
  localparam int unsigned DIGIT_GAP_MS   = 2000;
  localparam int unsigned PULSE_ON_MS    = 300;
  localparam int unsigned PULSE_OFF_MS   = 400;
  localparam int unsigned TICK_MS        = 1;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned SEL_W          = 6;
  localparam int unsigned CODE_W         = 8;
  localparam int unsigned DIGIT_W        = 4;
  localparam int unsigned MS_CNT_W       = 13;
  localparam int unsigned PRE_W          = 24;
  localparam int unsigned SYNC_STAGES    = 3;

  localparam logic [MS_CNT_W-1:0] MARKER_TICKS = MS_CNT_W'(MARKER_MS / TICK_MS);
  localparam logic [MS_CNT_W-1:0] GAP_TICKS    = MS_CNT_W'(DIGIT_GAP_MS / TICK_MS);
  localparam logic [MS_CNT_W-1:0] ON_TICKS     = MS_CNT_W'(PULSE_ON_MS / TICK_MS);
  localparam logic [MS_CNT_W-1:0] OFF_TICKS    = MS_CNT_W'(PULSE_OFF_MS / TICK_MS);
  localparam logic [MS_CNT_W-1:0] ONE_TICK     = 13'h0001;
  localparam logic [DIGIT_W-1:0]  DIGIT_ONE    = 4'h1;
  localparam logic [DIGIT_W-1:0]  DIGIT_ZERO   = 4'h0;
  localparam logic [CODE_W-1:0]   CODE_ZERO    = 8'h00;
  localparam logic [SEL_W-1:0]    SEL_ZERO     = 6'h00;
  localparam logic [PRE_W-1:0]    PRE_ZERO     = 24'h000000;
  localparam logic [PRE_W-1:0]    PRE_ONE      = 24'h000001;
  localparam logic [MS_CNT_W-1:0] MS_ZERO      = 13'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_MARK,
    ST_HI_ON,
    ST_HI_OFF,
    ST_GAP1,
    ST_LO_ON,
    ST_LO_OFF
  } blink_state_e;

endpackage

// >>> rtl/diag_led_error_blinker.sv
`timescale 1ns/1ps

module diag_led_error_blinker
  import diag_led_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [SEL_W-1:0]  test_select_jumpers_i,
  input  wire logic              diag_restart_i,
  input  wire logic              diag_pass_i,
  input  wire logic              diag_fail_i,
  input  wire logic [CODE_W-1:0] ext_status_code_i,
  output logic                   diag_start_o,
  output logic [SEL_W-1:0]       diag_select_o,
  output logic                   diag_running_o,
  output logic                   error_indicator_o,
  output logic                   ready_indicator_o
);

  // ****************************************
  // prescaler
  // ****************************************
  // ticks per millisecond; tracks the clock parameter so intervals stay true
  localparam logic [PRE_W-1:0] PRE_TICKS = PRE_W'((CLK_HZ / 1000) * TICK_MS);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic             tick;

  always_comb begin
    tick    = (pre_r == PRE_TICKS - PRE_ONE);
    pre_nxt = tick ? PRE_ZERO : pre_r + PRE_ONE;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_r <= PRE_ZERO;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // ****************************************
  // jumper synchroniser
  // ****************************************
  // jumpers are static straps; three stages and an agree check reject bounce
  logic [SEL_W-1:0] sel_s1_r;
  logic [SEL_W-1:0] sel_s2_r;
  logic [SEL_W-1:0] sel_s3_r;
  logic [SEL_W-1:0] sel_r;
  logic [SEL_W-1:0] sel_nxt;

  always_comb begin
    sel_nxt = (sel_s2_r == sel_s3_r) ? sel_s3_r : sel_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sel_s1_r <= SEL_ZERO;
      sel_s2_r <= SEL_ZERO;
      sel_s3_r <= SEL_ZERO;
      sel_r    <= SEL_ZERO;
    end else begin
      sel_s1_r <= test_select_jumpers_i;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      sel_r    <= sel_nxt;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  blink_state_e      st_r;
  blink_state_e      st_nxt;
  logic [MS_CNT_W-1:0] ms_r;
  logic [MS_CNT_W-1:0] ms_nxt;
  logic [DIGIT_W-1:0]  dig_r;
  logic [DIGIT_W-1:0]  dig_nxt;
  logic [CODE_W-1:0]   code_r;
  logic [CODE_W-1:0]   code_nxt;
  logic                rdy_r;
  logic                rdy_nxt;
  logic                err_r;
  logic                err_nxt;
  logic                start_r;
  logic                start_nxt;
  logic                expired;
  logic [DIGIT_W-1:0]  hi_dig;
  logic [DIGIT_W-1:0]  lo_dig;

  always_comb begin
    expired   = tick && (ms_r == ONE_TICK);
    hi_dig    = code_r[CODE_W-1:DIGIT_W];
    lo_dig    = code_r[DIGIT_W-1:0];
    st_nxt    = st_r;
    ms_nxt    = (tick && ms_r != MS_ZERO) ? ms_r - ONE_TICK : ms_r;
    dig_nxt   = dig_r;
    code_nxt  = code_r;
    rdy_nxt   = rdy_r;
    err_nxt   = err_r;
    start_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        // first cycle after reset starts a test unprompted, with diag_select_o still at SEL_ZERO
        st_nxt    = ST_RUN;
        start_nxt = 1'b1;
        rdy_nxt   = 1'b0;
        err_nxt   = 1'b0;
      end
      ST_RUN: begin
        if (diag_fail_i) begin
          st_nxt   = ST_MARK;
          code_nxt = ext_status_code_i;
          rdy_nxt  = 1'b0;
          err_nxt  = 1'b1;
          ms_nxt   = MARKER_TICKS;
        end else if (diag_pass_i) begin
          rdy_nxt   = ~rdy_r;
          start_nxt = 1'b1;
        end
      end
      ST_MARK: begin
        if (expired) begin
          err_nxt = 1'b0;
          if (hi_dig == DIGIT_ZERO) begin
            // zero digit: no pulses, straight to its gap
            st_nxt = ST_GAP1;
            ms_nxt = GAP_TICKS;
          end else begin
            // dark spacer first, else the first pulse merges into the marker
            st_nxt  = ST_HI_OFF;
            err_nxt = 1'b0;
            dig_nxt = hi_dig;
            ms_nxt  = OFF_TICKS;
          end
        end
      end
      ST_HI_ON, ST_LO_ON: begin
        if (expired) begin
          err_nxt = 1'b0;
          st_nxt  = (st_r == ST_HI_ON) ? ST_HI_OFF : ST_LO_OFF;
          dig_nxt = dig_r - DIGIT_ONE;
          // last pulse goes straight into the long gap
          ms_nxt  = (dig_r == DIGIT_ONE) ? GAP_TICKS : OFF_TICKS;
        end
      end
      ST_HI_OFF: begin
        if (expired) begin
          if (dig_r == DIGIT_ZERO) begin
            // the long gap was served here, lower digit follows directly
            if (lo_dig == DIGIT_ZERO) begin
              st_nxt = ST_LO_OFF;
              ms_nxt = GAP_TICKS;
            end else begin
              st_nxt  = ST_LO_ON;
              err_nxt = 1'b1;
              dig_nxt = lo_dig;
              ms_nxt  = ON_TICKS;
            end
          end else begin
            st_nxt  = ST_HI_ON;
            err_nxt = 1'b1;
            ms_nxt  = ON_TICKS;
          end
        end
      end
      ST_GAP1: begin
        if (expired) begin
          if (lo_dig == DIGIT_ZERO) begin
            st_nxt = ST_LO_OFF;
            ms_nxt = GAP_TICKS;
          end else begin
            st_nxt  = ST_LO_ON;
            err_nxt = 1'b1;
            dig_nxt = lo_dig;
            ms_nxt  = ON_TICKS;
          end
        end
      end
      ST_LO_OFF: begin
        if (expired) begin
          if (dig_r == DIGIT_ZERO) begin
            st_nxt  = ST_MARK;
            err_nxt = 1'b1;
            ms_nxt  = MARKER_TICKS;
          end else begin
            st_nxt  = ST_LO_ON;
            err_nxt = 1'b1;
            ms_nxt  = ON_TICKS;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // a new diagnostic start ends any blinking
    if (diag_restart_i) begin
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r    <= ST_IDLE;
      ms_r    <= MS_ZERO;
      dig_r   <= DIGIT_ZERO;
      code_r  <= CODE_ZERO;
      rdy_r   <= 1'b0;
      err_r   <= 1'b0;
      start_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ms_r    <= ms_nxt;
      dig_r   <= dig_nxt;
      code_r  <= code_nxt;
      rdy_r   <= rdy_nxt;
      err_r   <= err_nxt;
      start_r <= start_nxt;
    end
  end

  assign diag_start_o      = start_r;
  assign diag_select_o     = sel_r;
  assign diag_running_o    = (st_r == ST_RUN);
  assign error_indicator_o = err_r;
  assign ready_indicator_o = rdy_r;

endmodule

// >>> bench/diag_led_chk.sv
`timescale 1ns/1ps
module diag_led_chk
  import diag_led_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic [SEL_W-1:0]  test_select_jumpers_i,
  input wire logic              diag_restart_i,
  input wire logic              diag_pass_i,
  input wire logic              diag_fail_i,
  input wire logic [CODE_W-1:0] ext_status_code_i,
  input wire logic              diag_start_o,
  input wire logic [SEL_W-1:0]  diag_select_o,
  input wire logic              diag_running_o,
  input wire logic              error_indicator_o,
  input wire logic              ready_indicator_o
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_BOOT_START: assert property ($fell(rst_i) |-> ##1 diag_start_o)
    else $error("no start after reset");
  AST_PASS_TOGGLE: assert property (diag_running_o && diag_pass_i && !diag_fail_i |=>
    ready_indicator_o != $past(ready_indicator_o) && diag_start_o)
    else $error("pass did not toggle ready");
  AST_FAIL_STOP: assert property (diag_running_o && diag_fail_i |=>
    error_indicator_o && !ready_indicator_o && !diag_running_o)
    else $error("fail did not stop run");
  AST_RUN_DARK: assert property (diag_running_o |-> !error_indicator_o)
    else $error("error led on while running");
  AST_START_DARK: assert property ($rose(diag_running_o) |-> !ready_indicator_o)
    else $error("ready led on at start");
  AST_BLINK_NO_RDY: assert property (error_indicator_o |-> !ready_indicator_o)
    else $error("ready led on while blinking");
  AST_RESTART: assert property (diag_restart_i ##1 !diag_restart_i |=>
    diag_start_o && !error_indicator_o)
    else $error("restart not honoured");
  // jumpers are static straps, so a settled copy must match
  AST_SELECT: assert property (diag_running_o && diag_pass_i |=>
    diag_select_o == test_select_jumpers_i)
    else $error("select differs from jumpers");
endmodule

bind diag_led_error_blinker diag_led_chk u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .test_select_jumpers_i(test_select_jumpers_i),
  .diag_restart_i(diag_restart_i), .diag_pass_i(diag_pass_i), .diag_fail_i(diag_fail_i),
  .ext_status_code_i(ext_status_code_i), .diag_start_o(diag_start_o),
  .diag_select_o(diag_select_o), .diag_running_o(diag_running_o),
  .error_indicator_o(error_indicator_o), .ready_indicator_o(ready_indicator_o));

// >>> bench/test_diag_led_error_blinker.sv
`timescale 1ns/1ps
module test_diag_led_error_blinker
  import diag_led_pkg::*;
;
  // ****************
  // clock, dut
  // ****************
  localparam int unsigned HZ  = 4000;
  localparam int          MSC = HZ / 1000;
  logic              ref_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [SEL_W-1:0]  jmp = 6'h2b;
  logic              rst_req = 1'b0;
  logic              pass = 1'b0;
  logic              fail = 1'b0;
  logic [CODE_W-1:0] code = 8'h00;
  logic              start, run, err, rdy;
  logic [SEL_W-1:0]  sel;
  int                n_mismatch = 0;
  int                n_tests = 0;
  int                cyc = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  diag_led_error_blinker #(.CLK_HZ(HZ)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .test_select_jumpers_i(jmp),
    .diag_restart_i(rst_req), .diag_pass_i(pass), .diag_fail_i(fail),
    .ext_status_code_i(code), .diag_start_o(start), .diag_select_o(sel),
    .diag_running_o(run), .error_indicator_o(err), .ready_indicator_o(rdy));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded so a stuck led cannot hang the run
  task automatic run_len(input logic lvl, input int c0, output int ms);
    int c;
    c = c0;
    while (err === lvl && c < 20000) begin
      @(negedge ref_clk_i);
      c++;
    end
    ms = (c + MSC - 1) / MSC;
  endtask
  task automatic t_start();
    int c;
    c = 0;
    while (start !== 1'b1 && c < 8) begin
      @(negedge ref_clk_i);
      c++;
    end
    chk(16'(start), 16'h0001);
    chk(16'(run), 16'h0001);
    chk(16'({err, rdy}), 16'h0000);
  endtask
  task automatic t_pass();
    // let the jumper copy settle through its three stages first
    repeat (4) @(negedge ref_clk_i);
    pass = 1'b1;
    for (int i = 1; i <= 3; i++) begin
      @(negedge ref_clk_i);
      chk(16'(rdy), 16'(i % 2));
    end
    pass = 1'b0;
    chk(16'(sel), 16'(jmp));
  endtask
  task automatic t_fail();
    int ms, hi, lo, gaps;
    hi = 0;
    lo = 0;
    gaps = 0;
    code = 8'h12;
    fail = 1'b1;
    pass = 1'b1;
    @(negedge ref_clk_i);
    code = 8'h5a;
    chk(16'({err, rdy, run}), 16'h0004);
    // fault ignored while blinking, ready stays dark
    @(negedge ref_clk_i);
    fail = 1'b0;
    pass = 1'b0;
    chk(16'(rdy), 16'h0000);
    run_len(1'b1, 1, ms);
    chk(16'(ms), 16'(MARKER_MS));
    while (gaps < 2) begin
      run_len(1'b0, 0, ms);
      if (ms > PULSE_OFF_MS) begin
        chk(16'(ms), 16'(DIGIT_GAP_MS));
        gaps++;
      end
      if (gaps < 2) begin
        run_len(1'b1, 0, ms);
        chk(16'(ms), 16'(PULSE_ON_MS));
        if (gaps == 0) hi++;
        else lo++;
      end
    end
    chk(16'(hi), 16'h0001);
    chk(16'(lo), 16'h0002);
    run_len(1'b1, 0, ms);
    chk(16'(ms), 16'(MARKER_MS));
  endtask
  // ****************
  // sequence
  // ****************
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_start();
    $display("power-up start done");
    t_pass();
    $display("pass toggle done");
    t_fail();
    $display("error blink done");
    rst_req = 1'b1;
    @(negedge ref_clk_i);
    rst_req = 1'b0;
    t_start();
    $display("restart done");
    end_sim();
  end
endmodule
